/* File: rtl/fdrc_top.sv */
// Floppy rate, precompensation and drive select register bank on AHB-Lite
`timescale 1ns/1ps
`default_nettype none
module fdrc_top
  import fdrc_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        CE,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        FIFO_ACCESS,
  input  wire logic        STATUS_ACCESS,
  output logic             SELECT_DRIVE_ZERO_N,
  output logic             SELECT_DRIVE_ONE_N,
  output logic             MOTOR_ZERO_N,
  output logic             MOTOR_ONE_N,
  output logic             DENSITY_PIN_ZERO,
  output logic             DENSITY_PIN_ONE,
  output logic [1:0]       RATE_CODE,
  output logic [2:0]       EFFECTIVE_RATE,
  output logic [2:0]       WRITE_DELAY_SELECT_STEPS,
  output logic             WRITE_DELAY_SELECT_HALF_STEP,
  output logic [7:0]       WRITE_DELAY_SELECT_START_TRACK,
  output logic             CTRL_RESET,
  output logic             LOW_POWER,
  output logic             SEPARATOR_RUN,
  output logic             TAPE_ON_SELECTED
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus phase tracking
  fdrc_req_t   req_q;
  logic        req_valid_q;
  logic        rd_done_q;
  logic        rd_stall;
  logic        wr_en;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // Reads wait one cycle; CE low stalls the bus so no write is lost
  assign rd_stall  = req_valid_q & ~req_q.write & ~rd_done_q;
  assign HREADYOUT = CE & ~rd_stall;
  assign HRESP     = 1'b0;
  assign HRDATA    = rdata_q;
  assign wr_en     = CE & req_valid_q & req_q.write;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      req_valid_q <= 1'b0;
      req_q       <= '0;
    end else if (CE && HREADYOUT) begin
      req_valid_q <= HSEL & HTRANS[1] & HREADY;
      req_q       <= '{addr: HADDR[13:0], write: HWRITE};
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      rd_done_q <= 1'b0;
    end else if (CE) begin
      rd_done_q <= rd_stall;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]  drive_out_q;
  logic [3:0]  tape_q;
  logic [7:0]  rate_sel_q;
  logic [7:0]  shadow_q;
  logic [7:0]  type_cfg_q;
  logic [15:0] mode_q;
  logic [1:0]  rate_code_q;
  logic        swrst_q;
  logic        low_power_q;
  logic        ctrl_rst_q;
  logic        wr_drive, wr_tape, wr_rate, wr_cfg_rate, wr_type, wr_mode;
  logic [7:0]  wbyte;

  assign wbyte       = HWDATA[7:0];
  assign wr_drive    = wr_en && req_q.addr == ADDR_DRIVE_OUT;
  assign wr_tape     = wr_en && req_q.addr == ADDR_TAPE;
  assign wr_rate     = wr_en && req_q.addr == ADDR_RATE;
  assign wr_cfg_rate = wr_en && req_q.addr == ADDR_CFG_RATE;
  assign wr_type     = wr_en && req_q.addr == ADDR_TYPE_CFG;
  assign wr_mode     = wr_en && req_q.addr == ADDR_MODE;

  // Drive output register keeps its bits through software reset
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      drive_out_q <= DRIVE_OUT_RST;
    end else if (wr_drive) begin
      drive_out_q <= wbyte;  // see RULE21
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      tape_q <= TAPE_RST;
    end else if (wr_tape) begin
      tape_q <= wbyte[3:0];
    end
  end

  // Only a hardware reset reloads the rate select value
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      rate_sel_q <= RATE_RST;  // see RULE7
      shadow_q   <= RATE_RST;
    end else if (wr_rate) begin
      rate_sel_q <= {1'b0, wbyte[6:0]};
      shadow_q   <= wbyte;  // see RULE17
    end
  end

  // Latest write of either register sets the rate
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      rate_code_q <= RATE_RST[1:0];
    end else if (wr_rate || wr_cfg_rate) begin
      rate_code_q <= wbyte[1:0];  // see RULE6
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      type_cfg_q <= TYPE_CFG_RST;
      mode_q     <= MODE_RST;
    end else begin
      if (wr_type) begin
        type_cfg_q <= wbyte;
      end
      if (wr_mode) begin
        mode_q <= HWDATA[15:0];  // see RULE24
      end
    end
  end

  // Self clearing software reset pulse
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      swrst_q <= 1'b0;
    end else if (CE) begin
      swrst_q <= wr_rate & wbyte[RS_SWRST];  // see RULE16
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      ctrl_rst_q <= 1'b0;
    end else if (CE) begin
      ctrl_rst_q <= ~drive_out_q[DO_NRESET] | swrst_q;  // see RULE22
    end
  end

  // Entry wins over a wake event in the same cycle
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      low_power_q <= 1'b0;
    end else if (wr_rate && wbyte[RS_LOWPWR]) begin
      low_power_q <= 1'b1;  // see RULE14
    end else if (CE && (swrst_q || !drive_out_q[DO_NRESET] || FIFO_ACCESS
                        || STATUS_ACCESS)) begin
      low_power_q <= 1'b0;  // see RULE15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rate table, density and precompensation
  logic [1:0]  tbl;
  logic [1:0]  dtype;
  logic        density;
  fdrc_rate_t  rate_kind;
  logic [2:0]  pre_code;
  logic [2:0]  steps;
  logic [1:0]  type_id;
  fdrc_pins_t  pins_d;
  fdrc_pins_t  pins_q;
  logic        sel_a, sel_b;

  assign tbl      = mode_q[MD_TBL_LO +: 2];
  assign dtype    = mode_q[MD_TYPE_LO +: 2];
  assign pre_code = rate_sel_q[RS_PRE_HI:RS_PRE_LO];

  always_comb begin
    rate_kind = RATE_250K;
    density   = 1'b0;
    unique case (rate_code_q)
      2'h3: begin
        rate_kind = (tbl == TBL_TAPE2M) ? RATE_2M : RATE_1M;  // see RULE8
        density   = 1'b1;
      end
      2'h0: begin
        rate_kind = RATE_500K;
        density   = 1'b1;
      end
      2'h1: begin
        rate_kind = (tbl == TBL_THREE) ? RATE_500K : RATE_300K;  // see RULE9
        density   = 1'b0;
      end
      2'h2: begin
        rate_kind = RATE_250K;
        density   = 1'b0;
      end
    endcase
  end

  // Steps are 41.67 ns, or 20.8 ns at 2 Mbps
  always_comb begin
    if (pre_code == PRE_OFF) begin
      steps = 3'h0;  // see RULE10
    end else if (pre_code == PRE_DEFAULT) begin
      steps = (rate_kind == RATE_2M || rate_kind == RATE_1M) ? STEPS_ONE : STEPS_SLOW;  // see RULE11
    end else begin
      steps = pre_code;
    end
  end

  // Drive type ID picked by the selected drive number
  assign type_id = type_cfg_q[{drive_out_q[1:0], 1'b0} +: 2];  // see RULE4

  assign sel_a = drive_out_q[1:0] == 2'h0 && drive_out_q[DO_MOT0];
  assign sel_b = drive_out_q[1:0] == 2'h1 && drive_out_q[DO_MOT1];

  always_comb begin
    if (mode_q[MD_SWAP]) begin
      pins_d.sel1_n = ~sel_a;  // see RULE1
      pins_d.sel0_n = ~sel_b;
      pins_d.mot1_n = ~drive_out_q[DO_MOT0];
      pins_d.mot0_n = ~drive_out_q[DO_MOT1];
    end else begin
      pins_d.sel0_n = ~sel_a;  // see RULE21
      pins_d.sel1_n = ~sel_b;
      pins_d.mot0_n = ~drive_out_q[DO_MOT0];
      pins_d.mot1_n = ~drive_out_q[DO_MOT1];
    end
    unique case (dtype)
      2'h0: begin
        pins_d.den1 = rate_code_q[0];  // see RULE18
        pins_d.den0 = density;
      end
      2'h2: begin
        pins_d.den1 = rate_code_q[0];
        pins_d.den0 = rate_code_q[1];
      end
      2'h1: begin
        pins_d.den1 = rate_code_q[0];
        pins_d.den0 = ~density;
      end
      2'h3: begin
        pins_d.den1 = rate_code_q[1];
        pins_d.den0 = rate_code_q[0];
      end
    endcase
  end

  // Pins hold their level in low power; only SEPARATOR_RUN stops
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      pins_q              <= '{sel0_n: 1'b1, sel1_n: 1'b1, mot0_n: 1'b1, mot1_n: 1'b1,
                               den0: 1'b0, den1: 1'b0};
      RATE_CODE           <= RATE_RST[1:0];
      EFFECTIVE_RATE      <= RATE_250K;
      WRITE_DELAY_SELECT_STEPS       <= 3'h0;
      WRITE_DELAY_SELECT_HALF_STEP   <= 1'b0;
      WRITE_DELAY_SELECT_START_TRACK <= 8'h00;
      TAPE_ON_SELECTED    <= 1'b0;
    end else if (CE) begin
      pins_q              <= pins_d;
      RATE_CODE           <= rate_code_q;  // see RULE8
      EFFECTIVE_RATE      <= rate_kind;
      WRITE_DELAY_SELECT_STEPS       <= steps;
      WRITE_DELAY_SELECT_HALF_STEP   <= rate_kind == RATE_2M;
      WRITE_DELAY_SELECT_START_TRACK <= mode_q[MD_TRK_LO +: 8];  // see RULE12
      // Code 00 never matches drive 0 as a tape drive
      TAPE_ON_SELECTED    <= tape_q[1:0] != 2'h0 && tape_q[1:0] == drive_out_q[1:0];  // see RULE23
    end
  end

  assign SELECT_DRIVE_ZERO_N = pins_q.sel0_n;
  assign SELECT_DRIVE_ONE_N  = pins_q.sel1_n;
  assign MOTOR_ZERO_N        = pins_q.mot0_n;
  assign MOTOR_ONE_N         = pins_q.mot1_n;
  assign DENSITY_PIN_ZERO    = pins_q.den0;
  assign DENSITY_PIN_ONE     = pins_q.den1;
  assign CTRL_RESET          = ctrl_rst_q;
  assign LOW_POWER           = low_power_q;
  assign SEPARATOR_RUN       = ~low_power_q;  // see RULE25

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (req_q.addr)
      ADDR_DRIVE_OUT: rdata_d[7:0] = drive_out_q;
      ADDR_TAPE: begin
        if (mode_q[MD_ENH]) begin
          rdata_d[5:0] = {type_id, tape_q};  // see RULE3
        end else begin
          rdata_d[1:0] = tape_q[1:0];  // see RULE2
        end
      end
      ADDR_SHADOW:   rdata_d[7:0]  = shadow_q;
      ADDR_TYPE_CFG: rdata_d[7:0]  = type_cfg_q;
      ADDR_MODE:     rdata_d[15:0] = mode_q;
      ADDR_STATUS:   rdata_d[10:0] = {steps, rate_kind, rate_code_q, 1'b0,
                                      ctrl_rst_q, low_power_q};
      // Rate select and config rate are write only: zero
      default:       rdata_d = 32'h0000_0000;  // see RULE5
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      rdata_q <= 32'h0000_0000;
    end else if (CE && rd_stall) begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_rate_wr;
    wr_rate;
  endsequence
  sequence s_reset_pulse;
    swrst_q ##1 (ctrl_rst_q || !CE);
  endsequence

  chk_swrst_self_clear: assert property (  // see RULE16
    (s_rate_wr ##0 wbyte[RS_SWRST]) |=> s_reset_pulse ##0 !swrst_q[*1])
    else $error("software reset pulse not one cycle");
  chk_lowpwr_enter: assert property (  // see RULE14
    (s_rate_wr ##0 wbyte[RS_LOWPWR]) |=> LOW_POWER && !SEPARATOR_RUN)
    else $error("low power not entered");
  chk_lowpwr_wake: assert property (  // see RULE15
    LOW_POWER && CE && (FIFO_ACCESS || STATUS_ACCESS) && !wr_rate |=> !LOW_POWER)
    else $error("low power not left on access");
  chk_shadow_copy: assert property (  // see RULE17
    wr_rate |=> shadow_q == $past(wbyte))
    else $error("shadow does not hold written value");
  chk_rate_latest: assert property (  // see RULE6
    (wr_rate || wr_cfg_rate) ##1 (CE && !wr_rate && !wr_cfg_rate)
      |=> RATE_CODE == $past(wbyte[1:0], 2))
    else $error("rate output not latest write");
  chk_swrst_keeps_rate: assert property (  // see RULE7
    swrst_q && !wr_rate && !wr_cfg_rate |=> $stable(rate_sel_q) && $stable(rate_code_q))
    else $error("software reset changed rate select");
  chk_tape_normal: assert property (  // see RULE2
    rd_stall && CE && req_q.addr == ADDR_TAPE && !mode_q[MD_ENH]
      |=> HRDATA[31:2] == 30'h0 && HREADYOUT)
    else $error("normal tape read upper bits set");
  chk_tape_enh: assert property (  // see RULE3
    rd_stall && CE && req_q.addr == ADDR_TAPE && mode_q[MD_ENH]
      |=> HRDATA[5:4] == $past(type_cfg_q[{drive_out_q[1:0], 1'b0} +: 2]))
    else $error("type id readback wrong");
  chk_rate_wo: assert property (  // see RULE5
    rd_stall && CE && req_q.addr == ADDR_RATE |=> HRDATA == 32'h0)
    else $error("rate select register readable");
  chk_swap_select: assert property (  // see RULE1
    CE && mode_q[MD_SWAP] && drive_out_q[1:0] == 2'h0 && drive_out_q[DO_MOT0]
      |=> !SELECT_DRIVE_ONE_N && SELECT_DRIVE_ZERO_N)
    else $error("swapped select wrong");
  chk_three_mode: assert property (  // see RULE9
    CE && tbl == TBL_THREE && rate_code_q == 2'h1
      |=> EFFECTIVE_RATE == 3'(RATE_500K))
    else $error("three mode rate wrong");
  chk_write_delay_select_off: assert property (  // see RULE10
    CE && pre_code == PRE_OFF |=> WRITE_DELAY_SELECT_STEPS == 3'h0)
    else $error("write_delay_select off not zero");
  chk_dor_reset: assert property (  // see RULE22
    CE && !drive_out_q[DO_NRESET] ##1 CE |-> CTRL_RESET)
    else $error("controller not held in reset");

endmodule
`default_nettype wire

/* File: rtl/fdrc_pkg.sv */
// Constants and types for the floppy rate and drive control block
// Overview of operation
// RULE1: Swapped decode: select 0 with bit4 drives drive-1 select; motors swap too.
// RULE2: Normal mode tape register reads only tape bits 1:0, upper bits zero.
// RULE3: Enhanced mode two reads tape 1:0, boot drive 3:2, type ID 5:4.
// RULE4: Type ID is the drive_type_config bit pair chosen by drive select.
// RULE5: The rate select register is write only and has no read path.
// RULE6: Effective data rate is the latest write to rate select or config rate.
// RULE7: Hardware reset loads rate select with 02h; software reset leaves it unchanged.
// RULE8: Table 00 maps codes to rates and density level; rate bits equal code.
// RULE9: Table 01 makes code 01 give 500/250 Kbps, density zero.
// RULE10: Write_delay_select code 111 gives zero, 001-110 give steps, 000 the default.
// RULE11: Default write_delay_select is one step at 2M and 1M, three steps slower.
// RULE12: Write_delay_select starts at track zero unless the configure path changes it.
// RULE13: Software writes zero into rate select bit 5.
// RULE14: Writing bit 6 of rate select enters manual low power mode.
// RULE15: Low power ends on software reset, FIFO access or status access.
// RULE16: Writing bit 7 of rate select resets the controller, then self clears.
// RULE17: Every rate select write is readable from the shadow register at 0x1F.
// RULE18: Density pins follow the drive type mapping of rate bits and density.
// RULE19: Software picks rate table 00, 01 or 10 by drive kind.
// RULE20: Legacy software sets the rate through the config rate register.
// RULE21: Drive output bits 1:0 form one drive number; bits 4,5 are motors.
// RULE22: A zero in drive output bit 2 holds the controller in reset.
// RULE23: Tape code 00 assigns no drive; drive 0 never gets tape support.
// RULE24: Mode bits choose swapped decode and the enhanced tape layout.
// RULE25: Low power stops the separator and rate timing, keeping all registers; the code stops only SEPARATOR_RUN, rate outputs keep updating.
package fdrc_pkg;
  // Offsets are not word multiples, so they are word indices
  localparam logic [11:0] IDX_DRIVE_OUT  = 12'h3F2;
  localparam logic [11:0] IDX_TAPE       = 12'h3F3;
  localparam logic [11:0] IDX_RATE       = 12'h3F4;
  localparam logic [11:0] IDX_CFG_RATE   = 12'h3F7;
  localparam logic [11:0] IDX_SHADOW     = 12'h01F;
  localparam logic [11:0] IDX_TYPE_CFG   = 12'h020;
  localparam logic [11:0] IDX_MODE       = 12'h021;
  localparam logic [11:0] IDX_STATUS     = 12'h022;
  localparam logic [13:0] ADDR_DRIVE_OUT = {IDX_DRIVE_OUT, 2'h0};
  localparam logic [13:0] ADDR_TAPE      = {IDX_TAPE, 2'h0};
  localparam logic [13:0] ADDR_RATE      = {IDX_RATE, 2'h0};
  localparam logic [13:0] ADDR_CFG_RATE  = {IDX_CFG_RATE, 2'h0};
  localparam logic [13:0] ADDR_SHADOW    = {IDX_SHADOW, 2'h0};
  localparam logic [13:0] ADDR_TYPE_CFG  = {IDX_TYPE_CFG, 2'h0};
  localparam logic [13:0] ADDR_MODE      = {IDX_MODE, 2'h0};
  localparam logic [13:0] ADDR_STATUS    = {IDX_STATUS, 2'h0};
  // Reset values
  localparam logic [7:0]  RATE_RST       = 8'h02;
  localparam logic [7:0]  DRIVE_OUT_RST  = 8'h00;
  localparam logic [3:0]  TAPE_RST       = 4'h0;
  localparam logic [7:0]  TYPE_CFG_RST   = 8'h00;
  localparam logic [15:0] MODE_RST       = 16'h0000;
  // Field positions
  localparam int RS_SWRST   = 7;
  localparam int RS_LOWPWR  = 6;
  localparam int RS_PRE_HI  = 4;
  localparam int RS_PRE_LO  = 2;
  localparam int DO_NRESET  = 2;
  localparam int DO_MOT0    = 4;
  localparam int DO_MOT1    = 5;
  localparam int MD_SWAP    = 0;
  localparam int MD_ENH     = 1;
  localparam int MD_TBL_LO  = 2;
  localparam int MD_TYPE_LO = 4;
  localparam int MD_TRK_LO  = 8;
  // Write_delay_select codes, step counts and rate table codes
  localparam logic [2:0] PRE_OFF     = 3'h7;
  localparam logic [2:0] PRE_DEFAULT = 3'h0;
  localparam logic [2:0] STEPS_ONE   = 3'h1;
  localparam logic [2:0] STEPS_SLOW  = 3'h3;
  localparam logic [1:0] TBL_THREE   = 2'h1;
  localparam logic [1:0] TBL_TAPE2M  = 2'h2;

  typedef enum logic [2:0] {RATE_2M, RATE_1M, RATE_500K, RATE_300K, RATE_250K} fdrc_rate_t;

  typedef struct packed {
    logic [13:0] addr;
    logic        write;
  } fdrc_req_t;

  typedef struct packed {
    logic sel0_n;
    logic sel1_n;
    logic mot0_n;
    logic mot1_n;
    logic den0;
    logic den1;
  } fdrc_pins_t;
endpackage

/* File: dv/fdrc_drive_model.sv */
// Behavioural model of the two floppy drives on the cable
`timescale 1ns/1ps
`default_nettype none
module fdrc_drive_model
  import fdrc_pkg::*;
(
  input  wire fdrc_pins_t pins,
  output logic [1:0]      sel,
  output logic [1:0]      spin,
  output logic [1:0]      den,
  output logic            clash
);
  // A drive listens only while its select line is low
  assign sel   = {~pins.sel1_n, ~pins.sel0_n};
  // Spindle follows its motor line, selected or not
  assign spin  = {~pins.mot1_n, ~pins.mot0_n};
  assign den   = {pins.den1, pins.den0};
  // Both drives answering at once would fight on the cable
  assign clash = &sel;
endmodule
`default_nettype wire

/* File: dv/floppy_rate_drive_control_test.sv */
// Self-checking bench for the floppy rate and drive control block
`timescale 1ns/1ps
`default_nettype none
module floppy_rate_drive_control_test
  import fdrc_pkg::*;
;
  typedef struct packed {
    logic [31:0] m;
    logic [31:0] e;
  } fdrc_note_t;
  localparam logic [31:0] RATE_M = 32'h0FF0FFE0;
  localparam logic [31:0] DRV_M  = 32'h000F0001;
  localparam logic [31:0] LP_M   = 32'h0000001C;
  // Rows for drives 0 and 1, plus drive 3 with no select
  localparam logic [7:0] DRV_V [6] = '{8'h14, 8'h34, 8'h25, 8'h35, 8'h04, 8'h07};
  logic        clk     = 1'b0;
  logic        reset_n = 1'b0;
  logic        ce      = 1'b1;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic        fifo    = 1'b0;
  logic        stat    = 1'b0;
  logic        snap    = 1'b0;
  logic        rd_ph   = 1'b0;
  logic        hready;
  logic [31:0] hrdata;
  logic        hresp;
  logic [1:0]  rate_code;
  logic [2:0]  eff;
  logic [2:0]  steps;
  logic        half;
  logic [7:0]  track;
  logic        ctrl_rst;
  logic        low_pwr;
  logic        sep_run;
  logic        tape_sel;
  logic [1:0]  sel;
  logic [1:0]  spin;
  logic [1:0]  den;
  logic        clash;
  logic [31:0] got;
  logic [7:0]  cfg;
  logic [3:0]  tp;
  fdrc_note_t  q[$];
  fdrc_note_t  n;
  int          n_errors    = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  wire fdrc_pins_t pins;
  wire [31:0]  obs = {4'h0, track, sel, spin, den, rate_code, eff, steps, half,
                      low_pwr, sep_run, ctrl_rst, tape_sel, clash};

  fdrc_top DUT (
    .CLK(clk), .RESET_N(reset_n), .CE(ce), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .FIFO_ACCESS(fifo), .STATUS_ACCESS(stat),
    .SELECT_DRIVE_ZERO_N(pins.sel0_n), .SELECT_DRIVE_ONE_N(pins.sel1_n),
    .MOTOR_ZERO_N(pins.mot0_n), .MOTOR_ONE_N(pins.mot1_n),
    .DENSITY_PIN_ZERO(pins.den0), .DENSITY_PIN_ONE(pins.den1),
    .RATE_CODE(rate_code), .EFFECTIVE_RATE(eff), .WRITE_DELAY_SELECT_STEPS(steps),
    .WRITE_DELAY_SELECT_HALF_STEP(half), .WRITE_DELAY_SELECT_START_TRACK(track),
    .CTRL_RESET(ctrl_rst), .LOW_POWER(low_pwr), .SEPARATOR_RUN(sep_run),
    .TAPE_ON_SELECTED(tape_sel)
  );
  fdrc_drive_model drives (
    .pins(pins), .sel(sel), .spin(spin), .den(den), .clash(clash)
  );

  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rate_exp(logic [1:0] tb, logic [1:0] dt,
                                           logic [1:0] c, logic [2:0] p);
    logic [2:0] er;
    logic       dn;
    logic [1:0] pn;
    logic [2:0] st;
    er = (c == 2'h3) ? ((tb == 2'h2) ? 3'h0 : 3'h1) : (c == 2'h0) ? 3'h2 :
         (c == 2'h2) ? 3'h4 : (tb == 2'h1) ? 3'h2 : 3'h3;
    dn = (c == 2'h3) || (c == 2'h0);
    case (dt)
      2'h0: pn = {c[0], dn};
      2'h2: pn = {c[0], c[1]};
      2'h1: pn = {c[0], ~dn};
      default: pn = {c[1], c[0]};
    endcase
    st = (p == 3'h7) ? 3'h0 : (p != 3'h0) ? p : (er < 3'h2) ? 3'h1 : 3'h3;
    rate_exp = {16'h0, pn, c, er, st, er == 3'h0, 5'h0};
  endfunction

  function automatic logic [31:0] drv_exp(logic sw, logic [7:0] v);
    logic [1:0] s;
    s[0] = (v[1:0] == 2'h0) && v[4];
    s[1] = (v[1:0] == 2'h1) && v[5];
    if (sw) s = {s[0], s[1]};
    drv_exp = {12'h0, s, sw ? {v[4], v[5]} : {v[5], v[4]}, 16'h0};
  endfunction

  // Holds each phase until hready is seen high, as the bus demands
  task automatic bus(input logic w, input logic [13:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {18'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
  endtask

  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [13:0] a, input logic [31:0] e);
    q.push_back('{32'hFFFFFFFF, e});
    bus(1'b0, a, 32'h0);
  endtask

  // Extra edge first: pins settle one edge after the write lands
  task automatic look(input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    q.push_back('{m, e});
    snap <= 1'b1;
    @(posedge clk);
    snap <= 1'b0;
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if ((rd_ph && hready) || snap) begin
      n = q.pop_front();
      got = snap ? obs : hrdata;
      comparisons++;
      if ((got & n.m) !== n.e) begin
        n_errors++;
        $display("BAD %0t got %h want %h", $time, got & n.m, n.e);
      end
    end
    if (rd_ph && hready && hresp !== 1'b0) begin
      n_errors++;
      $display("BAD %0t error response", $time);
    end
    rd_ph <= hready ? (hsel && htrans[1] && !hwrite) : rd_ph;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      $display("BAD %0t timeout", $time);
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h2F6A));
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(ADDR_SHADOW, 32'h02);
    rd(ADDR_RATE, 32'h0);
    look(RATE_M, rate_exp(2'h0, 2'h0, 2'h2, 3'h0));
    look(LP_M, 32'h0C);
    wr(ADDR_DRIVE_OUT, 32'h04);
    look(LP_M, 32'h08);
    wr(14'h3FFC, 32'hFF);
    rd(14'h3FFC, 32'h0);
    $display("done reset and map");
    for (int tb = 0; tb < 4; tb++)
      for (int dt = 0; dt < 4; dt++)
        for (int c = 0; c < 4; c++) begin
          wr(ADDR_MODE, {26'h0, dt[1:0], tb[1:0], 2'h0});
          wr(ADDR_RATE, {30'h0, c[1:0]});
          look(RATE_M, rate_exp(tb[1:0], dt[1:0], c[1:0], 3'h0));
        end
    wr(ADDR_MODE, 32'h08);
    for (int p = 1; p < 8; p++) begin
      wr(ADDR_RATE, {27'h0, p[2:0], 2'h3});
      look(RATE_M, rate_exp(2'h2, 2'h0, 2'h3, p[2:0]));
      wr(ADDR_RATE, {27'h0, p[2:0], 2'h2});
      look(RATE_M, rate_exp(2'h2, 2'h0, 2'h2, p[2:0]));
    end
    $display("done rates");
    wr(ADDR_RATE, 32'h03);
    wr(ADDR_CFG_RATE, 32'h01);
    look(RATE_M, rate_exp(2'h2, 2'h0, 2'h1, 3'h0));
    rd(ADDR_SHADOW, 32'h03);
    wr(ADDR_MODE, 32'h2A00);
    look(32'h0FF00000, 32'h02A00000);
    rd(ADDR_MODE, 32'h2A00);
    $display("done config rate");
    for (int s = 0; s < 2; s++) begin
      wr(ADDR_MODE, {31'h0, s[0]});
      for (int i = 0; i < 6; i++) begin
        wr(ADDR_DRIVE_OUT, {24'h0, DRV_V[i]});
        look(DRV_M, drv_exp(s[0], DRV_V[i]));
      end
    end
    $display("done drive decode");
    cfg = 8'($urandom);
    wr(ADDR_TYPE_CFG, {24'h0, cfg});
    rd(ADDR_TYPE_CFG, {24'h0, cfg});
    for (int t = 0; t < 4; t++) begin
      tp = {2'($urandom), t[1:0]};
      wr(ADDR_TAPE, {28'h0, tp});
      for (int s = 0; s < 4; s++) begin
        wr(ADDR_DRIVE_OUT, {29'h1, s[1:0]});
        wr(ADDR_MODE, 32'h02);
        rd(ADDR_TAPE, {26'h0, cfg[2*s+:2], tp});
        wr(ADDR_MODE, 32'h00);
        rd(ADDR_TAPE, {30'h0, tp[1:0]});
        look(32'h2, {30'h0, tp[1:0] != 2'h0 && tp[1:0] == s[1:0], 1'b0});
      end
    end
    $display("done tape register");
    wr(ADDR_RATE, 32'h42);
    look(LP_M, 32'h10);
    rd(ADDR_SHADOW, 32'h42);
    // Access while CE is low must not wake: state is frozen
    ce   <= 1'b0;
    fifo <= 1'b1;
    @(posedge clk);
    ce   <= 1'b1;
    fifo <= 1'b0;
    look(LP_M, 32'h10);
    fifo <= 1'b1;
    @(posedge clk);
    fifo <= 1'b0;
    look(LP_M, 32'h08);
    wr(ADDR_RATE, 32'h42);
    stat <= 1'b1;
    @(posedge clk);
    stat <= 1'b0;
    look(LP_M, 32'h08);
    wr(ADDR_RATE, 32'h42);
    wr(ADDR_DRIVE_OUT, 32'h00);
    look(LP_M, 32'h0C);
    look(RATE_M, rate_exp(2'h0, 2'h0, 2'h2, 3'h0));
    wr(ADDR_DRIVE_OUT, 32'h04);
    rd(ADDR_DRIVE_OUT, 32'h04);
    $display("done low power");
    wr(ADDR_RATE, 32'h42);
    wr(ADDR_RATE, 32'h83);
    look(LP_M, 32'h0C);
    look(LP_M, 32'h08);
    look(RATE_M, rate_exp(2'h0, 2'h0, 2'h3, 3'h0));
    rd(ADDR_SHADOW, 32'h83);
    rd(ADDR_STATUS, 32'h138);
    $display("done software reset");
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(ADDR_SHADOW, 32'h02);
    look(RATE_M, rate_exp(2'h0, 2'h0, 2'h2, 3'h0));
    $display("done hardware reset");
    repeat (4) @(posedge clk);
    end_sim();
  end

endmodule
`default_nettype wire
